// ===== bench/debug_probe_model.sv
`timescale 1ns/1ps
module debug_probe_model (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic drvEn,
  input  wire logic drvLevel,
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic progReq,
  input  wire logic linkActive,
  input  wire logic spiProgAllowed,
  input  wire logic fuseWrGrant,
  output logic      pinLevel,
  output logic      swDisableCmd,
  output logic      fuseWrReq,
  output logic      fuseWrViaSpi,
  output logic      powerCycleReq
);
  logic [1:0] phase;
  // Released line sits at the probe pull-up
  assign pinLevel = pinOe ? pinOut : (drvEn ? drvLevel : 1'b1);
  // Fuse writes only through serial programming
  assign fuseWrViaSpi = fuseWrReq;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 2'h0;
      swDisableCmd <= 1'b0;
      fuseWrReq <= 1'b0;
      powerCycleReq <= 1'b0;
    end else begin
      swDisableCmd <= 1'b0;
      case (phase)
        2'h0: if (progReq) begin
          swDisableCmd <= linkActive;
          phase <= 2'h1;
        end
        2'h1: if (spiProgAllowed) begin
          fuseWrReq <= 1'b1;
          phase <= 2'h2;
        end
        2'h2: if (fuseWrGrant) begin
          fuseWrReq <= 1'b0;
          powerCycleReq <= 1'b1;
          phase <= 2'h3;
        end
        default: ;
      endcase
    end
  end
endmodule : debug_probe_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk, rstn, cfgWrite, cfgAddrRange, cfgValRange, pcValid, dataValid;
  logic        fetchValid, stepArm, haltReq, resume, swEnFuse, spiEnFuse, twoWireSel;
  logic        pinCfg, gpioOut, gpioOe, swTxEn, swTxBit, crcScanEn, crcDone, crcMatch;
  logic        chipErase, drvEn, drvLevel, progReq, cfgReject, cpuHalted, linkActive;
  logic        resetPinOut, resetPinOe, extResetReq, spiProgAllowed, clkKeepAlive;
  logic        fuseWrGrant, twClkRise, gpioIn, bitTick, rxBit, bootGo, resetPinIn;
  logic        swDisableCmd, fuseWrReq, fuseWrViaSpi, powerCycleReq;
  logic [2:0]  cfgMode, haltCause;
  logic [1:0]  cfgKindData, cfgArea0, cfgArea1, dataArea, lockBits;
  logic [15:0] cfgAddr0, cfgAddr1, pcAddr, dataAddr, fetchOpcode, stepAddr;
  logic [7:0]  cfgVal0, cfgVal1, dataValue, bitDiv;
  logic [15:0] flashPage [4], cached;
  int          n_mismatch = 0, check_count = 0, cyc = 0, lastTick = 0, period = 0;
  int          nTw = 0, t0;

  debug_breakpoint_unit debug_breakpoint_unit_inst (
    .sys_clk, .rstn, .cfgWrite, .cfgMode, .cfgKindData, .cfgArea0, .cfgArea1,
    .cfgAddrRange, .cfgValRange, .cfgAddr0, .cfgAddr1, .cfgVal0, .cfgVal1, .pcValid,
    .pcAddr, .dataValid, .dataAddr, .dataArea, .dataValue, .fetchValid, .fetchOpcode,
    .stepArm, .stepAddr, .haltReq, .resume, .swEnFuse, .spiEnFuse, .lockBits,
    .swDisableCmd, .fuseWrReq, .fuseWrViaSpi, .twoWireSel, .pinCfg, .gpioOut, .gpioOe,
    .swTxEn, .swTxBit, .bitDiv, .resetPinIn, .crcScanEn, .crcDone, .crcMatch, .chipErase,
    .cfgReject, .cpuHalted, .haltCause, .linkActive, .resetPinOut, .resetPinOe,
    .extResetReq, .spiProgAllowed, .clkKeepAlive, .fuseWrGrant, .twClkRise, .gpioIn,
    .bitTick, .rxBit, .bootGo
  );

  debug_probe_model debug_probe_model_inst (
    .sys_clk, .rstn, .drvEn, .drvLevel, .pinOut(resetPinOut), .pinOe(resetPinOe),
    .progReq, .linkActive, .spiProgAllowed, .fuseWrGrant, .pinLevel(resetPinIn),
    .swDisableCmd, .fuseWrReq, .fuseWrViaSpi, .powerCycleReq
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pulse outputs are counted and timed here
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (twClkRise === 1'b1) nTw <= nTw + 1;
    if (bitTick === 1'b1) begin
      period <= cyc - lastTick;
      lastTick <= cyc;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  task automatic pin(input logic lv, input int n);
    drvEn = !lv;
    drvLevel = lv;
    tick(n);
  endtask : pin

  task automatic power_on(input logic sw, input logic spi, input logic scan);
    rstn = 1'b0;
    swEnFuse = sw;
    spiEnFuse = spi;
    crcScanEn = scan;
    tick(8);
    chk("spiProgAllowed in reset", spiProgAllowed, 1'b1);
    rstn = 1'b1;
    tick(4);
  endtask : power_on

  task automatic cfg(input logic [2:0] m, input logic [1:0] k, input logic [1:0] a,
                     input logic ar, input logic vr, input logic rej);
    cfgMode = m;
    cfgKindData = k;
    cfgArea1 = a;
    cfgAddrRange = ar;
    cfgValRange = vr;
    pulse(cfgWrite);
    chk("cfgReject", cfgReject, rej);
    tick(1);
  endtask : cfg

  task automatic halt_chk(input logic [2:0] cause);
    tick(1);
    {pcValid, dataValid, fetchValid, haltReq} = 4'h0;
    chk("cpuHalted", cpuHalted, cause != 3'h0);
    if (cause != 3'h0) begin
      chk("haltCause", haltCause, cause);
      pulse(resume);
      chk("cpuHalted after resume", cpuHalted, 1'b0);
    end
    tick(1);
  endtask : halt_chk

  task automatic pc_hit(input logic [15:0] a, input logic [2:0] c);
    pcValid = 1'b1;
    pcAddr = a;
    halt_chk(c);
  endtask : pc_hit

  task automatic data_hit(input logic [15:0] a, input logic [1:0] ar, input logic [7:0] v,
                          input logic [2:0] c);
    dataValid = 1'b1;
    dataAddr = a;
    dataArea = ar;
    dataValue = v;
    halt_chk(c);
  endtask : data_hit

  // Probe side flash edit: the whole page is rewritten each time
  task automatic page_write(input int idx, input logic [15:0] w);
    logic [15:0] pg [4];
    pg = flashPage;
    pg[idx] = w;
    flashPage = pg;
  endtask : page_write

  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {cfgWrite, cfgAddrRange, cfgValRange, pcValid, dataValid, fetchValid, stepArm, haltReq,
     resume, twoWireSel, pinCfg, gpioOut, gpioOe, swTxEn, swTxBit, crcDone, crcMatch,
     chipErase, drvEn, drvLevel, progReq, cfgMode, cfgKindData, cfgArea1, dataArea,
     lockBits, cfgAddr0, cfgAddr1, pcAddr, dataAddr, fetchOpcode, stepAddr, cfgVal0,
     cfgVal1, dataValue} = '0;
    cfgArea0 = dbg_pkg::AREA_SRAM;
    bitDiv = 8'h03;
    power_on(1'b0, 1'b1, 1'b1);
    chk("bootGo", bootGo, 1'b0);
    pulse(crcDone);
    tick(1);
    chk("bootGo", bootGo, 1'b0);
    crcMatch = 1'b1;
    pulse(crcDone);
    tick(1);
    chk("bootGo", bootGo, 1'b0);
    pulse(chipErase);
    pulse(crcDone);
    tick(1);
    chk("bootGo", bootGo, 1'b1);
    cfg(3'h0, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0);
    cfg(3'h4, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1);
    cfg(3'h5, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1);
    cfg(3'h1, 2'h1, 2'h1, 1'b0, 1'b0, 1'b1);
    cfg(3'h1, 2'h3, 2'h2, 1'b0, 1'b0, 1'b1);
    cfg(3'h6, 2'h3, 2'h1, 1'b0, 1'b0, 1'b1);
    cfgAddr0 = 16'h0100;
    cfgAddr1 = 16'h0200;
    cfg(3'h1, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0);
    cfg(3'h7, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1);
    pc_hit(16'h0200, dbg_pkg::CAUSE_HWBP);
    pc_hit(16'h0101, dbg_pkg::CAUSE_NONE);
    data_hit(16'h0100, dbg_pkg::AREA_SRAM, 8'h00, dbg_pkg::CAUSE_NONE);
    cfg(3'h3, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0);
    pc_hit(16'h0200, dbg_pkg::CAUSE_HWBP);
    pc_hit(16'h0150, dbg_pkg::CAUSE_HWBP);
    pc_hit(16'h0201, dbg_pkg::CAUSE_NONE);
    cfgVal0 = 8'h5A;
    cfg(3'h2, 2'h3, 2'h1, 1'b0, 1'b0, 1'b0);
    data_hit(16'h0200, dbg_pkg::AREA_SRAM, 8'h5A, dbg_pkg::CAUSE_HWBP);
    data_hit(16'h0200, dbg_pkg::AREA_SRAM, 8'h5B, dbg_pkg::CAUSE_NONE);
    data_hit(16'h0100, dbg_pkg::AREA_IO, 8'h5A, dbg_pkg::CAUSE_NONE);
    pc_hit(16'h0100, dbg_pkg::CAUSE_NONE);
    cfgVal0 = 8'h10;
    cfgVal1 = 8'h20;
    cfg(3'h6, 2'h3, 2'h1, 1'b0, 1'b1, 1'b0);
    data_hit(16'h0100, dbg_pkg::AREA_SRAM, 8'h20, dbg_pkg::CAUSE_HWBP);
    data_hit(16'h0100, dbg_pkg::AREA_SRAM, 8'h21, dbg_pkg::CAUSE_NONE);
    data_hit(16'h0200, dbg_pkg::AREA_SRAM, 8'h15, dbg_pkg::CAUSE_NONE);
    twoWireSel = 1'b1;
    flashPage = '{16'h0000, 16'h1234, 16'h0000, 16'h0000};
    cached = flashPage[1];
    page_write(1, dbg_pkg::BREAK_OPCODE);
    fetchValid = 1'b1;
    fetchOpcode = flashPage[1];
    halt_chk(dbg_pkg::CAUSE_SWBP);
    fetchValid = 1'b1;
    fetchOpcode = cached;
    halt_chk(dbg_pkg::CAUSE_NONE);
    page_write(1, cached);
    chk("flash word restored", flashPage[1], 16'h1234);
    twoWireSel = 1'b0;
    chk("spiProgAllowed", spiProgAllowed, 1'b1);
    pin(1'b0, 5);
    chk("extResetReq", extResetReq, 1'b1);
    pinCfg = 1'b1;
    tick(5);
    chk("extResetReq", extResetReq, 1'b0);
    chk("gpioIn", gpioIn, 1'b0);
    {gpioOe, gpioOut} = 2'h3;
    tick(5);
    chk("gpioIn", gpioIn, 1'b1);
    chk("resetPinOe", resetPinOe, 1'b1);
    {gpioOe, gpioOut, pinCfg} = 3'h0;
    twoWireSel = 1'b1;
    t0 = nTw;
    pin(1'b1, 5);
    pin(1'b0, 5);
    chk("extResetReq", extResetReq, 1'b0);
    pin(1'b1, 5);
    chk("twClkRise count", 16'(nTw - t0), 16'h0001);
    haltReq = 1'b1;
    halt_chk(dbg_pkg::CAUSE_HOST);
    twoWireSel = 1'b0;
    power_on(1'b1, 1'b1, 1'b0);
    chk("linkActive", linkActive, 1'b1);
    chk("spiProgAllowed", spiProgAllowed, 1'b0);
    chk("clkKeepAlive", clkKeepAlive, 1'b1);
    swEnFuse = 1'b0;
    pin(1'b0, 5);
    chk("linkActive", linkActive, 1'b1);
    chk("extResetReq", extResetReq, 1'b0);
    {swTxEn, swTxBit} = 2'h2;
    tick(2);
    chk("resetPinOe", resetPinOe, 1'b1);
    chk("resetPinOut", resetPinOut, 1'b0);
    swTxEn = 1'b0;
    pin(1'b1, 12);
    chk("rxBit", rxBit, 1'b1);
    chk("bitTick period", 16'(period), 16'h0004);
    cfg(3'h1, 2'h0, 2'h1, 1'b0, 1'b0, 1'b0);
    pc_hit(16'h0100, dbg_pkg::CAUSE_NONE);
    stepAddr = 16'h0300;
    pulse(stepArm);
    pc_hit(16'h0300, dbg_pkg::CAUSE_STEP);
    pc_hit(16'h0300, dbg_pkg::CAUSE_NONE);
    lockBits = 2'h1;
    tick(2);
    chk("linkActive", linkActive, 1'b0);
    lockBits = 2'h0;
    tick(2);
    pulse(progReq);
    for (int i = 0; i < 20 && powerCycleReq !== 1'b1; i++)
      tick(1);
    chk("powerCycleReq", powerCycleReq, 1'b1);
    chk("linkActive", linkActive, 1'b0);
    chk("spiProgAllowed", spiProgAllowed, 1'b1);
    power_on(1'b0, 1'b1, 1'b0);
    chk("linkActive", linkActive, 1'b0);
    power_on(1'b1, 1'b0, 1'b0);
    pulse(progReq);
    tick(6);
    chk("linkActive", linkActive, 1'b1);
    chk("spiProgAllowed", spiProgAllowed, 1'b0);
    wrap_up();
  end
endmodule : tb_top

// ===== src/dbg_pkg.sv
package dbg_pkg;
  localparam int              ADDR_W       = 16;
  localparam int              DATA_W       = 8;
  // Break opcode encoding, arbitrary value
  localparam logic [15:0]     BREAK_OPCODE = 16'h95F8;
  localparam logic [2:0]      CAUSE_NONE   = 3'h0;
  localparam logic [2:0]      CAUSE_HWBP   = 3'h1;
  localparam logic [2:0]      CAUSE_SWBP   = 3'h2;
  localparam logic [2:0]      CAUSE_STEP   = 3'h3;
  localparam logic [2:0]      CAUSE_HOST   = 3'h4;
  localparam logic [7:0]      DIV_RESET    = 8'h00;
  localparam logic [1:0]      RST_SYNC_RST = 2'h0;

  typedef enum logic [2:0] {
    BP_OFF          = 3'h0,
    BP_TWO_ADDR     = 3'h1,
    BP_TWO_ADDR_VAL = 3'h2,
    BP_ADDR_RANGE   = 3'h3,
    BP_DATA_RANGE   = 3'h6
  } bp_mode_t;

  typedef enum logic [1:0] {
    AREA_IO   = 2'h0,
    AREA_SRAM = 2'h1,
    AREA_XRAM = 2'h2
  } area_t;

  typedef enum logic {
    CPU_RUN    = 1'b0,
    CPU_HALTED = 1'b1
  } cpu_state_t;

  typedef enum logic [1:0] {
    BOOT_SCAN = 2'h0,
    BOOT_RUN  = 2'h1,
    BOOT_LOCK = 2'h3
  } boot_state_t;

  typedef enum logic {
    PIN_RESET = 1'b0,
    PIN_GPIO  = 1'b1
  } pin_cfg_t;
endpackage : dbg_pkg

// ===== src/debug_breakpoint_unit.sv
// Notes on behaviour
// - Four comparators: two address, two value
// - Active breakpoints all program or all data
// - Data breakpoints share one memory area
// - Address range uses both comparators exclusively
// - Only the four listed comparator combinations
// - Two-wire interface clocks from reset pin
// - Link enabled: pin is no reset input
// - Link works only with enable fuse set
// - Link cannot program its own enable fuse
// - Fuse change effective after power cycle
// - Link can disable itself when serial fuse set
// - Enable fuse keeps clocks alive in sleep
// - Link works only with lock bits cleared
// - Reduced unit: one step comparator only
// - Fetched break opcode halts the CPU while link or two-wire mode is on
// - Link bit rate derives from system clock
// - Enabled link excludes serial programming
// - Shared pin configurable as reset or GPIO
// - CRC mismatch blocks boot until recovery
`timescale 1ns/1ps
module debug_breakpoint_unit (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        cfgWrite,
  input  wire logic [2:0]  cfgMode,
  input  wire logic [1:0]  cfgKindData,
  input  wire logic [1:0]  cfgArea0,
  input  wire logic [1:0]  cfgArea1,
  input  wire logic        cfgAddrRange,
  input  wire logic        cfgValRange,
  input  wire logic [15:0] cfgAddr0,
  input  wire logic [15:0] cfgAddr1,
  input  wire logic [7:0]  cfgVal0,
  input  wire logic [7:0]  cfgVal1,
  input  wire logic        pcValid,
  input  wire logic [15:0] pcAddr,
  input  wire logic        dataValid,
  input  wire logic [15:0] dataAddr,
  input  wire logic [1:0]  dataArea,
  input  wire logic [7:0]  dataValue,
  input  wire logic        fetchValid,
  input  wire logic [15:0] fetchOpcode,
  input  wire logic        stepArm,
  input  wire logic [15:0] stepAddr,
  input  wire logic        haltReq,
  input  wire logic        resume,
  input  wire logic        swEnFuse,
  input  wire logic        spiEnFuse,
  input  wire logic [1:0]  lockBits,
  input  wire logic        swDisableCmd,
  input  wire logic        fuseWrReq,
  input  wire logic        fuseWrViaSpi,
  input  wire logic        twoWireSel,
  input  wire logic        pinCfg,
  input  wire logic        gpioOut,
  input  wire logic        gpioOe,
  input  wire logic        swTxEn,
  input  wire logic        swTxBit,
  input  wire logic [7:0]  bitDiv,
  input  wire logic        resetPinIn,
  input  wire logic        crcScanEn,
  input  wire logic        crcDone,
  input  wire logic        crcMatch,
  input  wire logic        chipErase,
  output logic             cfgReject,
  output logic             cpuHalted,
  output logic [2:0]       haltCause,
  output logic             linkActive,
  output logic             resetPinOut,
  output logic             resetPinOe,
  output logic             extResetReq,
  output logic             spiProgAllowed,
  output logic             clkKeepAlive,
  output logic             fuseWrGrant,
  output logic             twClkRise,
  output logic             gpioIn,
  output logic             bitTick,
  output logic             rxBit,
  output logic             bootGo
);

  typedef struct packed {
    dbg_pkg::bp_mode_t    mode;
    logic                 kindData;
    logic [1:0]           area;
    logic                 addrRange;
    logic                 valRange;
    logic [15:0]          c0;
    logic [15:0]          c1;
    logic [7:0]           v0;
    logic [7:0]           v1;
    logic                 cfgReject;
    dbg_pkg::cpu_state_t  cpu;
    logic [2:0]           haltCause;
    logic                 stepArmed;
    logic [15:0]          stepAddr;
    logic                 fuseCaptured;
    logic                 swFuse;
    logic                 spiFuse;
    logic                 tempOff;
    logic                 linkActive;
    logic                 pinS1;
    logic                 pinS2;
    logic                 pinPrev;
    logic                 pinOut;
    logic                 pinOe;
    logic                 extResetReq;
    logic                 spiProgAllowed;
    logic                 clkKeepAlive;
    logic                 fuseWrGrant;
    logic                 twClkRise;
    logic                 gpioIn;
    logic [7:0]           divCnt;
    logic                 bitTick;
    logic                 rxBit;
    dbg_pkg::boot_state_t boot;
    logic                 erased;
    logic                 bootGo;
  } state_t;

  state_t     s;
  state_t     next_s;
  logic [1:0] rstSync;
  logic       rst_n;
  logic       legal;
  logic       debugEn;
  logic       swBreak;
  logic       hwHit;
  logic       stepHit;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction : inRange

  // Legal comparator combination check
  function automatic logic cfgLegal(input logic [2:0] m, input logic [1:0] kd,
                                    input logic [1:0] a0, input logic [1:0] a1,
                                    input logic ar, input logic vr);
    logic same;
    same = (kd[0] == kd[1]) && (!kd[0] || (a0 == a1));
    case (m)
      dbg_pkg::BP_OFF:          cfgLegal = 1'b1;
      dbg_pkg::BP_TWO_ADDR:     cfgLegal = same;
      dbg_pkg::BP_ADDR_RANGE:   cfgLegal = same;
      dbg_pkg::BP_TWO_ADDR_VAL: cfgLegal = same && kd[0];
      dbg_pkg::BP_DATA_RANGE:   cfgLegal = same && kd[0] && (ar || vr);
      default:                  cfgLegal = 1'b0;
    endcase
  endfunction : cfgLegal

  // One comparison across the four comparators
  function automatic logic bpMatch(input state_t st, input logic [15:0] a,
                                   input logic [7:0] v);
    logic aHit;
    aHit = (a == st.c0) || (a == st.c1);
    case (st.mode)
      dbg_pkg::BP_TWO_ADDR:     bpMatch = aHit;
      dbg_pkg::BP_ADDR_RANGE:   bpMatch = inRange(a, st.c0, st.c1);
      dbg_pkg::BP_TWO_ADDR_VAL: bpMatch = aHit && (v == st.v0);
      dbg_pkg::BP_DATA_RANGE:
        bpMatch = (st.addrRange ? inRange(a, st.c0, st.c1) : (a == st.c0)) &&
                  (st.valRange ? inRange({8'h00, v}, {8'h00, st.v0}, {8'h00, st.v1})
                               : (v == st.v0));
      default:                  bpMatch = 1'b0;
    endcase
  endfunction : bpMatch

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync <= dbg_pkg::RST_SYNC_RST;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rst_n = rstSync[1];

  assign legal   = cfgLegal(cfgMode, cfgKindData, cfgArea0, cfgArea1, cfgAddrRange,
                            cfgValRange);
  assign debugEn = s.linkActive || twoWireSel;
  assign swBreak = debugEn && fetchValid && (fetchOpcode == dbg_pkg::BREAK_OPCODE);
  // Reduced unit has no user comparators while the link runs
  assign hwHit   = !s.linkActive && s.mode != dbg_pkg::BP_OFF &&
                   ((pcValid && !s.kindData && bpMatch(s, pcAddr, 8'h00)) ||
                    (dataValid && s.kindData && dataArea == s.area &&
                     bpMatch(s, dataAddr, dataValue)));
  assign stepHit = s.stepArmed && pcValid && (pcAddr == s.stepAddr);

  always_comb begin
    next_s = s;
    next_s.twClkRise = 1'b0;
    next_s.bitTick   = 1'b0;
    next_s.fuseWrGrant = 1'b0;
    // Breakpoint configuration
    if (cfgWrite) begin
      next_s.cfgReject = !legal;
      if (legal) begin
        next_s.mode      = dbg_pkg::bp_mode_t'(cfgMode);
        next_s.kindData  = cfgKindData[0];
        next_s.area      = cfgArea0;
        next_s.addrRange = cfgAddrRange;
        next_s.valRange  = cfgValRange;
        next_s.c0        = cfgAddr0;
        next_s.c1        = cfgAddr1;
        next_s.v0        = cfgVal0;
        next_s.v1        = cfgVal1;
      end
    end
    // CPU run control
    if (stepArm) begin
      next_s.stepArmed = 1'b1;
      next_s.stepAddr  = stepAddr;
    end
    case (s.cpu)
      dbg_pkg::CPU_RUN: begin
        if (swBreak) begin
          next_s.cpu       = dbg_pkg::CPU_HALTED;
          next_s.haltCause = dbg_pkg::CAUSE_SWBP;
        end else if (hwHit) begin
          next_s.cpu       = dbg_pkg::CPU_HALTED;
          next_s.haltCause = dbg_pkg::CAUSE_HWBP;
        end else if (stepHit) begin
          next_s.cpu       = dbg_pkg::CPU_HALTED;
          next_s.haltCause = dbg_pkg::CAUSE_STEP;
          next_s.stepArmed = 1'b0;
        end else if (haltReq && debugEn) begin
          next_s.cpu       = dbg_pkg::CPU_HALTED;
          next_s.haltCause = dbg_pkg::CAUSE_HOST;
        end
      end
      dbg_pkg::CPU_HALTED: begin
        if (resume) begin
          next_s.cpu = dbg_pkg::CPU_RUN;
        end
      end
      default: next_s.cpu = dbg_pkg::CPU_RUN;
    endcase
    // Fuses are sampled once per power-up
    if (!s.fuseCaptured) begin
      next_s.fuseCaptured = 1'b1;
      next_s.swFuse       = swEnFuse;
      next_s.spiFuse      = spiEnFuse;
    end
    if (swDisableCmd && s.linkActive && s.spiFuse) begin
      next_s.tempOff = 1'b1;
    end
    next_s.linkActive = next_s.swFuse && !next_s.tempOff && (lockBits == 2'h0);
    // Shared reset pin
    next_s.pinS1   = resetPinIn;
    next_s.pinS2   = s.pinS1;
    next_s.pinPrev = s.pinS2;
    next_s.gpioIn  = s.pinS2;
    next_s.twClkRise   = twoWireSel && s.pinS2 && !s.pinPrev;
    next_s.extResetReq = !s.linkActive && !twoWireSel && pinCfg == dbg_pkg::PIN_RESET &&
                         !s.pinS2;
    if (s.linkActive) begin
      next_s.pinOe  = swTxEn;
      next_s.pinOut = swTxBit;
    end else begin
      next_s.pinOe  = !twoWireSel && pinCfg == dbg_pkg::PIN_GPIO && gpioOe;
      next_s.pinOut = gpioOut;
    end
    next_s.spiProgAllowed = !s.linkActive;
    next_s.clkKeepAlive   = s.swFuse;
    next_s.fuseWrGrant    = fuseWrReq && fuseWrViaSpi && !s.linkActive;
    // Bit timing from the system clock
    if (!s.linkActive) begin
      next_s.divCnt = bitDiv;
    end else if (s.divCnt == 8'h00) begin
      next_s.divCnt  = bitDiv;
      next_s.bitTick = 1'b1;
      next_s.rxBit   = s.pinS2;
    end else begin
      next_s.divCnt = s.divCnt - 8'h01;
    end
    // Pre-boot flash check
    if (chipErase) begin
      next_s.erased = 1'b1;
    end
    case (s.boot)
      dbg_pkg::BOOT_SCAN: begin
        if (!crcScanEn || (crcDone && crcMatch)) begin
          next_s.boot = dbg_pkg::BOOT_RUN;
        end else if (crcDone) begin
          next_s.boot = dbg_pkg::BOOT_LOCK;
        end
      end
      dbg_pkg::BOOT_LOCK: begin
        if (!crcScanEn || (s.erased && crcDone && crcMatch)) begin
          next_s.boot = dbg_pkg::BOOT_RUN;
        end
      end
      dbg_pkg::BOOT_RUN: next_s.boot = dbg_pkg::BOOT_RUN;
      default:           next_s.boot = dbg_pkg::BOOT_SCAN;
    endcase
    next_s.bootGo = next_s.boot == dbg_pkg::BOOT_RUN;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s           <= '0;
      s.mode      <= dbg_pkg::BP_OFF;
      s.cpu       <= dbg_pkg::CPU_RUN;
      s.haltCause <= dbg_pkg::CAUSE_NONE;
      s.divCnt    <= dbg_pkg::DIV_RESET;
      s.boot      <= dbg_pkg::BOOT_SCAN;
      s.spiProgAllowed <= 1'b1;
      // Pin copies start at the pulled-up idle level, no false edge
      s.pinS1     <= 1'b1;
      s.pinS2     <= 1'b1;
      s.pinPrev   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign cfgReject      = s.cfgReject;
  assign cpuHalted      = s.cpu == dbg_pkg::CPU_HALTED;
  assign haltCause      = s.haltCause;
  assign linkActive     = s.linkActive;
  assign resetPinOut    = s.pinOut;
  assign resetPinOe     = s.pinOe;
  assign extResetReq    = s.extResetReq;
  assign spiProgAllowed = s.spiProgAllowed;
  assign clkKeepAlive   = s.clkKeepAlive;
  assign fuseWrGrant    = s.fuseWrGrant;
  assign twClkRise      = s.twClkRise;
  assign gpioIn         = s.gpioIn;
  assign bitTick        = s.bitTick;
  assign rxBit          = s.rxBit;
  assign bootGo         = s.bootGo;

  sequence s_mixed_kind;
    cfgWrite && (cfgKindData[0] != cfgKindData[1]) && cfgMode != dbg_pkg::BP_OFF;
  endsequence
  property p_mixed_rejected;
    s_mixed_kind |=> cfgReject && $stable(s.mode);
  endproperty
  a_mixed_rejected: assert property (p_mixed_rejected) else $error("mixed kinds taken");

  property p_area_rejected;
    cfgWrite && cfgKindData == 2'h3 && cfgArea0 != cfgArea1 &&
    cfgMode != dbg_pkg::BP_OFF |=> cfgReject;
  endproperty
  a_area_rejected: assert property (p_area_rejected) else $error("mixed areas taken");

  sequence s_break_fetch;
    !cpuHalted && debugEn && fetchValid && fetchOpcode == dbg_pkg::BREAK_OPCODE;
  endsequence
  property p_break_halts;
    s_break_fetch |=> cpuHalted && haltCause == dbg_pkg::CAUSE_SWBP ##1
                      (cpuHalted || $past(resume));
  endproperty
  a_break_halts: assert property (p_break_halts) else $error("break did not halt");

  property p_no_ext_reset;
    linkActive |=> !extResetReq;
  endproperty
  a_no_ext_reset: assert property (p_no_ext_reset) else $error("reset while linked");

  property p_fuse_frozen;
    s.fuseCaptured && $past(s.fuseCaptured) |=> $stable(clkKeepAlive) && $stable(s.swFuse);
  endproperty
  a_fuse_frozen: assert property (p_fuse_frozen) else $error("fuse changed live");

  property p_temp_disable;
    swDisableCmd && linkActive && s.spiFuse |=> !linkActive ##1 spiProgAllowed;
  endproperty
  a_temp_disable: assert property (p_temp_disable) else $error("link kept pin");

  property p_locked_no_link;
    lockBits != 2'h0 |=> !linkActive;
  endproperty
  a_locked_no_link: assert property (p_locked_no_link) else $error("link with locks");

  property p_no_self_fuse;
    linkActive |=> !fuseWrGrant;
  endproperty
  a_no_self_fuse: assert property (p_no_self_fuse) else $error("link wrote fuse");

  sequence s_crc_bad;
    s.boot == dbg_pkg::BOOT_SCAN && crcScanEn && crcDone && !crcMatch;
  endsequence
  property p_crc_lock;
    s_crc_bad |=> !bootGo ##1 (!bootGo || !$past(crcScanEn) || $past(crcMatch));
  endproperty
  a_crc_lock: assert property (p_crc_lock) else $error("booted on bad crc");

endmodule : debug_breakpoint_unit
